// ===== core/ieb_top.sv
/*
 * interrupt enable bank: main and auxiliary enable registers that
 * gate the microcontroller's interrupt sources toward the core, plus
 * the wake-up enables for stop and halt mode, a sticky event status
 * with mask and one summary interrupt line.
 * assumes request inputs are levels synchronous to clock and that the
 * register port follows a one-cycle strobe protocol.
 */
// Operation
// - global gate low blocks every request toward the core; status already set still drives irq
// - main bit 5 enables timer 2
// - main bit 4 enables uart 1
// - main bit 3 enables timer 1
// - main bit 2 enables pin 1, wake
// - main bit 1 enables timer 0
// - main bit 0 enables pin 0, wake
// - aux bit 7 enables pwm group
// - aux bits 6..4: two-wire, uart 2, spi
// - aux bit 3 enables adc and touch
// - aux bit 2: pins 2-9, wake, lowvolt
// - aux bit 1 enables port 1 change
// - aux bit 0: timer 3, halt wake
`timescale 1ns/10ps
module ieb_top (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // main bank sources
  input  wire logic       timer0_req,
  input  wire logic       timer1_req,
  input  wire logic       timer2_req,
  input  wire logic       uart1_req,
  input  wire logic       ext_pin0,
  input  wire logic       ext_pin1,
  // auxiliary bank sources
  input  wire logic       pwm_group_req,
  input  wire logic       two_wire_req,
  input  wire logic       uart2_req,
  input  wire logic       spi_req,
  input  wire logic       adc_touch_req,
  input  wire logic [7:0] ext_pins_2_to_9,
  input  wire logic       low_voltage_detect,
  input  wire logic       port1_change_req,
  input  wire logic       timer3_req,
  // gated requests toward the core
  output logic      [7:0] main_irq_out,
  output logic      [7:0] aux_irq_out,
  // wake-up requests toward power control
  output logic            stop_halt_wake,
  output logic            halt_wake,
  // summary interrupt
  output logic            irq
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic       rst_meta_n;       // first reset stage
  logic       rst_n;            // released reset for the design
  logic [7:0] irq_enable_main;  // main enable register
  logic [7:0] irq_enable_aux;   // auxiliary enable register
  logic [7:0] mask_main;        // status mask, main layout
  logic [7:0] mask_aux;         // status mask, auxiliary layout
  logic [7:0] status_main;      // sticky status, main layout
  logic [7:0] status_aux;       // sticky status, auxiliary layout
  logic       pend_main;        // unmasked main event pending
  logic       pend_aux;         // unmasked aux event pending
  logic       clr_main;         // read of main status
  logic       clr_aux;          // read of aux status
  logic [7:0] next_rdata;       // read mux result
  logic       pins_2_9_any;     // any of the upper external pins
  logic       global_irq_gate;  // main register bit 7

  // one bundle per enable register
  ieb_bank_if main_bank ();
  ieb_bank_if aux_bank ();

  // ------------------------------------------------------------------
  // address decode shared by read and write paths
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------

  // two-stage release of the asynchronous reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ------------------------------------------------------------------
  // enable registers
  // ------------------------------------------------------------------

  // main enable register; unused bit is never stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_main <= ieb_pkg::RST_ENABLE;
    end else if (reg_write && hit(reg_addr, ieb_pkg::OFF_MAIN)) begin
      irq_enable_main <= reg_wdata & ieb_pkg::MAIN_WMASK;
    end
  end

  // auxiliary enable register; every bit writable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_aux <= ieb_pkg::RST_ENABLE;
    end else if (reg_write && hit(reg_addr, ieb_pkg::OFF_AUX)) begin
      irq_enable_aux <= reg_wdata & ieb_pkg::AUX_WMASK;
    end
  end

  // ------------------------------------------------------------------
  // mask registers
  // ------------------------------------------------------------------

  // main-layout mask; unused bit kept at zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_main <= ieb_pkg::RST_MASK;
    end else if (reg_write && hit(reg_addr, ieb_pkg::OFF_MASK_MAIN)) begin
      mask_main <= reg_wdata & ieb_pkg::MAIN_WMASK;
    end
  end

  // auxiliary-layout mask
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_aux <= ieb_pkg::RST_MASK;
    end else if (reg_write && hit(reg_addr, ieb_pkg::OFF_MASK_AUX)) begin
      mask_aux <= reg_wdata & ieb_pkg::AUX_WMASK;
    end
  end

  // ------------------------------------------------------------------
  // main bank request assembly
  // ------------------------------------------------------------------

  // global gate sits in the top bit of the main register
  assign global_irq_gate = irq_enable_main[ieb_pkg::GATE_BIT];

  // source lines placed at their enable positions
  always_comb begin
    main_bank.req                  = 8'h00;
    main_bank.req[ieb_pkg::T2_BIT] = timer2_req;
    main_bank.req[ieb_pkg::U1_BIT] = uart1_req;
    main_bank.req[ieb_pkg::T1_BIT] = timer1_req;
    main_bank.req[ieb_pkg::X1_BIT] = ext_pin1;
    main_bank.req[ieb_pkg::T0_BIT] = timer0_req;
    main_bank.req[ieb_pkg::X0_BIT] = ext_pin0;
  end

  // enables, with the gate bit itself removed from the vector
  assign main_bank.en = irq_enable_main &
                        ~(8'h01 << ieb_pkg::GATE_BIT);
  // same global gate drives both banks
  assign main_bank.gate = global_irq_gate;

  // ------------------------------------------------------------------
  // auxiliary bank request assembly
  // ------------------------------------------------------------------

  // upper pins share one enable with each other
  assign pins_2_9_any = |ext_pins_2_to_9;

  // source lines placed at their enable positions
  always_comb begin
    aux_bank.req                   = 8'h00;
    aux_bank.req[ieb_pkg::PWM_BIT] = pwm_group_req;
    aux_bank.req[ieb_pkg::TW_BIT]  = two_wire_req;
    aux_bank.req[ieb_pkg::U2_BIT]  = uart2_req;
    aux_bank.req[ieb_pkg::SPI_BIT] = spi_req;
    aux_bank.req[ieb_pkg::ADC_BIT] = adc_touch_req;
    aux_bank.req[ieb_pkg::XLV_BIT] = pins_2_9_any |
                                     low_voltage_detect;
    aux_bank.req[ieb_pkg::P1_BIT]  = port1_change_req;
    aux_bank.req[ieb_pkg::T3_BIT]  = timer3_req;
  end

  // every aux bit is an enable
  assign aux_bank.en = irq_enable_aux;
  // aux sources obey the global gate too
  assign aux_bank.gate = global_irq_gate;

  // ------------------------------------------------------------------
  // gating
  // ------------------------------------------------------------------

  // main bank gating
  ieb_gate u_gate_main (
    .bank (main_bank)
  );

  // auxiliary bank gating
  ieb_gate u_gate_aux (
    .bank (aux_bank)
  );

  // gated requests leave as levels toward the core
  assign main_irq_out = main_bank.gated;
  assign aux_irq_out  = aux_bank.gated;

  // ------------------------------------------------------------------
  // wake-up paths
  // ------------------------------------------------------------------

  // pin wake needs only the pin's own enable, not the global gate
  assign stop_halt_wake =
      (ext_pin0 & irq_enable_main[ieb_pkg::X0_BIT]) |
      (ext_pin1 & irq_enable_main[ieb_pkg::X1_BIT]) |
      (pins_2_9_any & irq_enable_aux[ieb_pkg::XLV_BIT]);

  // halt also wakes on timer 3
  assign halt_wake = stop_halt_wake |
      (timer3_req & irq_enable_aux[ieb_pkg::T3_BIT]);

  // ------------------------------------------------------------------
  // event status
  // ------------------------------------------------------------------

  // a read strobe on a status offset clears it
  assign clr_main = reg_read && hit(reg_addr, ieb_pkg::OFF_STAT_MAIN);
  assign clr_aux  = reg_read && hit(reg_addr, ieb_pkg::OFF_STAT_AUX);

  // sticky status for main-layout events
  ieb_sticky u_stat_main (
    .clock   (clock),
    .rst_n   (rst_n),
    .bank    (main_bank),
    .clear   (clr_main),
    .mask    (mask_main),
    .status  (status_main),
    .pending (pend_main)
  );

  // sticky status for aux-layout events
  ieb_sticky u_stat_aux (
    .clock   (clock),
    .rst_n   (rst_n),
    .bank    (aux_bank),
    .clear   (clr_aux),
    .mask    (mask_aux),
    .status  (status_aux),
    .pending (pend_aux)
  );

  // level interrupt while any unmasked status bit is set
  assign irq = pend_main | pend_aux;

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = ieb_pkg::RD_NONE;
    if (hit(reg_addr, ieb_pkg::OFF_MAIN)) begin
      // unused bit never stored, reads zero
      next_rdata = irq_enable_main;
    end else if (hit(reg_addr, ieb_pkg::OFF_AUX)) begin
      next_rdata = irq_enable_aux;
    end else if (hit(reg_addr, ieb_pkg::OFF_STAT_MAIN)) begin
      next_rdata = status_main;
    end else if (hit(reg_addr, ieb_pkg::OFF_STAT_AUX)) begin
      next_rdata = status_aux;
    end else if (hit(reg_addr, ieb_pkg::OFF_MASK_MAIN)) begin
      next_rdata = mask_main;
    end else if (hit(reg_addr, ieb_pkg::OFF_MASK_AUX)) begin
      next_rdata = mask_aux;
    end
  end

  // read data stand for one cycle after the strobe, else zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ieb_pkg::RD_NONE;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= ieb_pkg::RD_NONE;
    end
  end

endmodule

// ===== core/ieb_pkg.sv
/*
 * constants of the interrupt enable bank: register offsets, bit
 * positions, write masks and reset values.
 * assumes an 8-bit register port with byte-wide offsets.
 */
package ieb_pkg;
  // register offsets on the 8-bit register port
  localparam logic [7:0] OFF_MAIN      = 8'hA8;
  localparam logic [7:0] OFF_AUX       = 8'hA9;
  localparam logic [7:0] OFF_STAT_MAIN = 8'hB4;
  localparam logic [7:0] OFF_STAT_AUX  = 8'hB5;
  localparam logic [7:0] OFF_MASK_MAIN = 8'hB6;
  localparam logic [7:0] OFF_MASK_AUX  = 8'hB7;
  // main enable register fields
  localparam int GATE_BIT = 7;
  localparam int T2_BIT   = 5;
  localparam int U1_BIT   = 4;
  localparam int T1_BIT   = 3;
  localparam int X1_BIT   = 2;
  localparam int T0_BIT   = 1;
  localparam int X0_BIT   = 0;
  // auxiliary enable register fields
  localparam int PWM_BIT  = 7;
  localparam int TW_BIT   = 6;
  localparam int U2_BIT   = 5;
  localparam int SPI_BIT  = 4;
  localparam int ADC_BIT  = 3;
  localparam int XLV_BIT  = 2;
  localparam int P1_BIT   = 1;
  localparam int T3_BIT   = 0;
  // writable bits and reset values
  localparam logic [7:0] MAIN_WMASK = 8'hBF;
  localparam logic [7:0] AUX_WMASK  = 8'hFF;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RD_NONE    = 8'h00;
endpackage

// ===== core/ieb_bank_if.sv
/*
 * bundle of one enable bank: raw requests, enables, global gate and
 * the gated requests.
 * assumes one instance per enable register inside the top module.
 */
`timescale 1ns/10ps
interface ieb_bank_if;
  logic [7:0] req;    // raw source requests
  logic [7:0] en;     // per-source enables
  logic       gate;   // global gate
  logic [7:0] gated;  // requests passed on
  // gating logic side
  modport gate_side (input req, input en, input gate, output gated);
  // status logic side
  modport stat_side (input gated);
endinterface

// ===== core/ieb_gate.sv
/*
 * per-bit gating of one bank of interrupt requests.
 * assumes request and enable vectors share one bit layout.
 */
`timescale 1ns/10ps
module ieb_gate (
  // bank bundle
  ieb_bank_if.gate_side bank
);
  // one and-gate per source
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // blocked while the global gate is low
      assign bank.gated[i] = bank.req[i] & bank.en[i] & bank.gate;
    end
  endgenerate
endmodule

// ===== core/ieb_sticky.sv
/*
 * sticky status bits for one bank, set on a rising gated request,
 * cleared by a read, with a mask onto one pending flag.
 * assumes clear is a one-cycle pulse on the register read strobe.
 */
`timescale 1ns/10ps
module ieb_sticky (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // gated requests
  ieb_bank_if.stat_side   bank,
  // software side
  input  wire logic       clear,
  input  wire logic [7:0] mask,
  output logic      [7:0] status,
  output logic            pending
);
  logic [7:0] prev;        // gated requests one cycle ago
  logic [7:0] rise;        // new events this cycle
  logic [7:0] next_status; // status after this cycle

  // rising edge of each gated request
  assign rise = bank.gated & ~prev;
  // set wins over a clear in the same cycle
  assign next_status = rise | (status & ~({8{clear}}));

  // previous request sample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 8'h00;
    end else begin
      prev <= bank.gated;
    end
  end

  // sticky status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= ieb_pkg::RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // any unmasked bit pending
  assign pending = |(status & mask);
endmodule

// ===== testbench/ieb_props.sv
/*
 * port-level assertions on the interrupt enable bank.
 * assumes binding onto ieb_top; one clock domain.
 */
`timescale 1ns/10ps
module ieb_props (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // main bank sources
  input wire logic       timer0_req,
  input wire logic       timer1_req,
  input wire logic       timer2_req,
  input wire logic       uart1_req,
  input wire logic       ext_pin0,
  input wire logic       ext_pin1,
  // auxiliary bank sources
  input wire logic       pwm_group_req,
  input wire logic       two_wire_req,
  input wire logic       uart2_req,
  input wire logic       spi_req,
  input wire logic       adc_touch_req,
  input wire logic [7:0] ext_pins_2_to_9,
  input wire logic       low_voltage_detect,
  input wire logic       port1_change_req,
  input wire logic       timer3_req,
  // outputs under watch
  input wire logic [7:0] main_irq_out,
  input wire logic [7:0] aux_irq_out,
  input wire logic       stop_halt_wake,
  input wire logic       halt_wake,
  input wire logic       irq
);
  logic       gate_seen; // last gate bit written
  logic [7:0] main_req;  // requests in main layout
  logic [7:0] aux_req;   // requests in aux layout
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // requests rearranged to the register layouts
  assign main_req = {2'h0, timer2_req, uart1_req, timer1_req, ext_pin1,
                     timer0_req, ext_pin0};
  assign aux_req = {pwm_group_req, two_wire_req, uart2_req, spi_req,
                    adc_touch_req, (|ext_pins_2_to_9) | low_voltage_detect,
                    port1_change_req, timer3_req};
  // follow the gate bit through main register writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gate_seen <= 1'h0;
    end else if (reg_write && reg_addr == 8'hA8) begin
      gate_seen <= reg_wdata[7];
    end
  end
  a_gate_blocks_all: assert property (
    !gate_seen |-> main_irq_out == 8'h00 && aux_irq_out == 8'h00)
    else $error("request passed with gate closed");
  a_main_follows_en: assert property (
    (reg_write && reg_addr == 8'hA8) |=> main_irq_out ==
    (main_req & $past(reg_wdata) & {8{$past(reg_wdata[7])}}))
    else $error("main outputs differ from enables");
  a_aux_follows_en: assert property (
    (reg_write && reg_addr == 8'hA9) |=> aux_irq_out ==
    (aux_req & $past(reg_wdata) & {8{gate_seen}}))
    else $error("aux outputs differ from enables");
  a_spare_bit_zero: assert property (
    (reg_read && reg_addr == 8'hA8) |=> reg_rdata[6] == 1'h0)
    else $error("spare main bit read as one");
  a_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  a_wake_has_pin: assert property (
    stop_halt_wake |-> ext_pin0 || ext_pin1 || (|ext_pins_2_to_9))
    else $error("wake without pin request");
  a_halt_wake_src: assert property (
    halt_wake |-> stop_halt_wake || timer3_req)
    else $error("halt wake without source");
  a_stop_in_halt: assert property (
    stop_halt_wake |-> halt_wake)
    else $error("stop wake missing from halt wake");
  a_irq_has_cause: assert property (
    $rose(irq) |-> $past(|{main_irq_out, aux_irq_out}) || $past(reg_write))
    else $error("irq rose without gated event");
endmodule

// ===== testbench/ieb_src_model.sv
/*
 * interrupt sources at the far side of the enable bank.
 * assumes the bench sets one packed level vector after clock edges.
 */
`timescale 1ns/10ps
module ieb_src_model (
  // packed levels: main 22:17, aux 16:9, pins 8:1, low voltage 0
  input  wire logic [22:0] src,
  // request levels toward the bank
  output logic             timer0_req,
  output logic             timer1_req,
  output logic             timer2_req,
  output logic             uart1_req,
  output logic             ext_pin0,
  output logic             ext_pin1,
  output logic             pwm_group_req,
  output logic             two_wire_req,
  output logic             uart2_req,
  output logic             spi_req,
  output logic             adc_touch_req,
  output logic      [7:0]  ext_pins_2_to_9,
  output logic             low_voltage_detect,
  output logic             port1_change_req,
  output logic             timer3_req
);
  // main layout, bit 17 is pin 0
  assign {timer2_req, uart1_req, timer1_req, ext_pin1, timer0_req,
          ext_pin0} = src[22:17];
  // aux layout, bit 11 left to pins and low voltage
  assign {pwm_group_req, two_wire_req, uart2_req, spi_req,
          adc_touch_req} = src[16:12];
  assign {port1_change_req, timer3_req} = src[10:9];
  assign ext_pins_2_to_9 = src[8:1];
  assign low_voltage_detect = src[0];
endmodule

// ===== testbench/interrupt_enable_bank_tb.sv
/*
 * self-checking bench of the interrupt enable bank.
 * assumes ieb_top, ieb_src_model and ieb_props are compiled first.
 */
`timescale 1ns/10ps
module interrupt_enable_bank_tb;
  logic        clock, reset_n, reg_write, reg_read; // bench driven
  logic  [7:0] reg_addr, reg_wdata;                 // register port
  logic [22:0] src;                                 // source levels
  wire         timer0_req, timer1_req, timer2_req, uart1_req;
  wire         ext_pin0, ext_pin1, pwm_group_req, two_wire_req;
  wire         uart2_req, spi_req, adc_touch_req, low_voltage_detect;
  wire         port1_change_req, timer3_req, stop_halt_wake;
  wire         halt_wake, irq;
  wire   [7:0] ext_pins_2_to_9, reg_rdata, main_irq_out, aux_irq_out;
  int          num_errors;                          // mismatches
  int          checks;                              // comparisons
  ieb_top u_dut (.*);
  ieb_src_model u_src (.*);
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one strobe cycle, write or read
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clock);
    reg_write <= w;
    reg_read  <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'h0;
    reg_read  <= 1'h0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'h0, a, 8'h00);
    chk(reg_rdata, e);
  endtask
  // new source levels
  task automatic drive(input logic [22:0] v);
    @(posedge clock);
    src <= v;
    #1;
  endtask
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  // reset values, spare bit, unmapped read
  task automatic t_regs;
    logic [7:0] offs [6];
    offs = '{8'hA8, 8'hA9, 8'hB4, 8'hB5, 8'hB6, 8'hB7};
    foreach (offs[i]) rd(offs[i], 8'h00);
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'hBF);
    wr(8'hA8, 8'h40);
    rd(8'hA8, 8'h00);
    wr(8'hA9, 8'hFF);
    rd(8'hA9, 8'hFF);
    rd(8'hC0, 8'h00);
    $display("regs done");
  endtask
  // each main enable alone, then gate closed
  task automatic t_main;
    logic [7:0] m;
    drive(23'h7FFFFF);
    for (int i = 0; i < 6; i++) begin
      m = 8'h01 << i;
      wr(8'hA8, 8'h80 | m);
      chk(main_irq_out, m);
    end
    wr(8'hA8, 8'h3F);
    chk(main_irq_out, 8'h00);
    chk(aux_irq_out, 8'h00);
    $display("main done");
  endtask
  // each aux enable alone, low voltage without wake
  task automatic t_aux;
    logic [7:0] m;
    wr(8'hA8, 8'h80);
    drive(23'h01FFFF);
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(8'hA9, m);
      chk(aux_irq_out, m);
    end
    drive(23'h000001);
    wr(8'hA9, 8'h04);
    chk(aux_irq_out, 8'h04);
    chk(stop_halt_wake, 1'h0);
    $display("aux done");
  endtask
  // wake paths with the gate closed
  task automatic t_wake;
    wr(8'hA9, 8'h00);
    wr(8'hA8, 8'h00);
    drive(23'h020000);
    chk(stop_halt_wake, 1'h0);
    wr(8'hA8, 8'h01);
    chk(stop_halt_wake, 1'h1);
    chk(main_irq_out, 8'h00);
    drive(23'h080000);
    chk(stop_halt_wake, 1'h0);
    wr(8'hA8, 8'h04);
    chk(stop_halt_wake, 1'h1);
    drive(23'h000100);
    wr(8'hA9, 8'h04);
    chk(stop_halt_wake, 1'h1);
    drive(23'h000200);
    wr(8'hA9, 8'h01);
    chk(stop_halt_wake, 1'h0);
    chk(halt_wake, 1'h1);
    $display("wake done");
  endtask
  // sticky status, mask and clear on read
  task automatic t_irq;
    wr(8'hA8, 8'hA0);
    drive(23'h000000);
    xfer(1'h0, 8'hB4, 8'h00);
    xfer(1'h0, 8'hB5, 8'h00);
    wr(8'hB6, 8'h20);
    drive(23'h400000);
    step;
    chk(irq, 1'h1);
    rd(8'hB4, 8'h20);
    chk(irq, 1'h0);
    wr(8'hB6, 8'h00);
    drive(23'h000000);
    drive(23'h400000);
    step;
    chk(irq, 1'h0);
    rd(8'hB4, 8'h20);
    wr(8'hB7, 8'h01);
    drive(23'h000200);
    step;
    chk(irq, 1'h1);
    rd(8'hB5, 8'h01);
    chk(irq, 1'h0);
    $display("irq done");
  endtask
  // verdict and end of run
  task automatic complete_run;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // free-running system clock
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // main sequence
  initial begin
    reset_n   = 1'h0;
    reg_write = 1'h0;
    reg_read  = 1'h0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    src       = 23'h000000;
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    repeat (3) @(posedge clock);
    t_regs;
    t_main;
    t_aux;
    t_wake;
    t_irq;
    complete_run;
  end
  // hang guard, well past the hundred or so cycles needed
  initial begin
    #(50 * 4000);
    num_errors++;
    complete_run;
  end
endmodule
bind ieb_top ieb_props u_props (.*);
